/* File: hw/rsc_pkg.sv */
// Purpose: constants for the remote sensor channel setup block
// Assumes: 20-bit register frame, 16-bit payload in the low bits
// Notes: offsets are register addresses of the serial command frame
`default_nettype none
package rsc_pkg;
  localparam logic [6:0] RSC_ADDR_CFG1 = 7'h4a;
  localparam logic [6:0] RSC_ADDR_CFG2 = 7'h4b;
  localparam logic [6:0] RSC_ADDR_CTRL = 7'h4e;
  localparam int RSC_TRACK_BIT = 14;
  localparam int RSC_STARTOFF_BIT = 13;
  localparam int RSC_BLANK_BIT = 10;
  localparam int RSC_TYPE_LSB = 0;
  localparam int RSC_CH1_ON_BIT = 3;
  localparam int RSC_CH0_ON_BIT = 1;
  localparam logic [15:0] RSC_CFG_RESET = 16'h0000;
  localparam logic [15:0] RSC_CTRL_RESET = 16'h0000;
  localparam logic [15:0] RSC_CFG_MASK = 16'h640f;
  localparam logic [15:0] RSC_CTRL_MASK = 16'h000a;
  // decoded frame formats
  typedef enum logic [3:0] {
    RSC_FMT_8_125 = 4'h1,
    RSC_FMT_8_189 = 4'h2,
    RSC_FMT_10_125 = 4'h4,
    RSC_FMT_10_189 = 4'h8
  } rsc_fmt_e;
  localparam int RSC_TRACK_FAST_US = 8;
  localparam int RSC_TRACK_SLOW_US = 16;
  localparam int RSC_BLANK_SHORT_MS = 5;
  localparam int RSC_BLANK_LONG_MS = 10;
  localparam int RSC_CLK_MHZ = 50;
  localparam int RSC_BLANK_SHORT_CYC = RSC_BLANK_SHORT_MS * 1000 * RSC_CLK_MHZ;
  localparam int RSC_BLANK_LONG_CYC = RSC_BLANK_LONG_MS * 1000 * RSC_CLK_MHZ;
  localparam int RSC_TRACK_FAST_CYC = RSC_TRACK_FAST_US * RSC_CLK_MHZ;
  localparam int RSC_TRACK_SLOW_CYC = RSC_TRACK_SLOW_US * RSC_CLK_MHZ;
endpackage
`default_nettype wire

/* File: hw/rsc_chan.sv */
// Purpose: decode one channel's configuration word into receiver controls
// Assumes: config word stable between register writes
// Notes: purely combinational
`default_nettype none
module rsc_chan
  import rsc_pkg::*;
(
  // configuration
  input wire logic [15:0] cfg,
  // decoded controls
  output logic track_slow,
  output logic use_start_period,
  output logic blank_long,
  output rsc_pkg::rsc_fmt_e frame_format
);
  wire logic [3:0] type_code = cfg[RSC_TYPE_LSB +: 4];
  assign track_slow = cfg[RSC_TRACK_BIT]; // RQ1
  assign use_start_period = ~cfg[RSC_STARTOFF_BIT]; // RQ2
  assign blank_long = cfg[RSC_BLANK_BIT]; // RQ3
  assign frame_format = (type_code == 4'h0) ? RSC_FMT_8_125 : // RQ5
                        (type_code == 4'h1) ? RSC_FMT_8_189 : // RQ5
                        (type_code == 4'h2) ? RSC_FMT_10_125 : // RQ6
                        RSC_FMT_10_189; // RQ6 RQ7
endmodule
`default_nettype wire

/* File: hw/rsc_top.sv */
// Purpose: two-channel remote sensor setup registers and decoded controls
// Assumes: serial frame decoded elsewhere into addr, write strobe and data
// Notes: reinit pulse returns all settings to reset values
//
// Contract
// RQ1: tracking bit selects slow base-current tracking
// RQ2: start-period decode off when bit set
// RQ3: blanking select: 0 is 5ms, 1 is 10ms
// RQ4: settings change only on write or reinit; the code also clears them to reset values on rst
// RQ5: codes 0000/0001 select 8-bit 125k/189k
// RQ6: codes 0010/0011 select 10-bit 125k/189k
// RQ7: codes 0100-1111 act as 10-bit 189k
// RQ8: sensor type resets to 0000
// RQ9: control bits 3 and 1 enable channels
// RQ10: on/off status follows enable, cleared by reinit
// RQ11: unassigned bits read zero, writes ignored
`default_nettype none
module rsc_top
  import rsc_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic state_machine_reinit,
  // register access
  input wire logic [6:0] reg_addr,
  input wire logic reg_write,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // per-channel controls
  output logic [CHANNELS-1:0] tracking_rate_halve,
  output logic [CHANNELS-1:0] start_period_decode_use,
  output logic [CHANNELS-1:0] limit_blanking_long,
  output logic [CHANNELS*4-1:0] sensor_frame_format,
  output logic [CHANNELS-1:0] channel_output_on,
  output logic [CHANNELS-1:0] channel_on_status
);
  import rsc_pkg::*;

  // the address decode serves exactly two configuration registers
  if (CHANNELS != 2) begin : g_bad_channels
    $error("rsc_top supports exactly two channels");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] sensor_channel_config [CHANNELS];
  logic [15:0] sensor_channel_control;
  logic [CHANNELS-1:0] on_status;

  wire logic clear_all = rst | state_machine_reinit;
  wire logic wr_cfg1 = reg_write & (reg_addr == RSC_ADDR_CFG1);
  wire logic wr_cfg2 = reg_write & (reg_addr == RSC_ADDR_CFG2);
  wire logic wr_ctrl = reg_write & (reg_addr == RSC_ADDR_CTRL);
  wire logic [CHANNELS-1:0] wr_cfg = {wr_cfg2, wr_cfg1};
  wire logic [CHANNELS-1:0] ctrl_bits = {reg_wdata[RSC_CH1_ON_BIT], reg_wdata[RSC_CH0_ON_BIT]};

  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      sensor_channel_control <= RSC_CTRL_RESET; // RQ4
    end else if (wr_ctrl) begin
      sensor_channel_control <= reg_wdata & RSC_CTRL_MASK; // RQ9 RQ11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      on_status <= '0; // RQ10
    end else if (wr_ctrl) begin
      on_status <= ctrl_bits; // RQ10
    end
  end

  // ----------------------------------------
  // per-channel decode
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      rsc_fmt_e fmt;
      always_ff @(posedge clk_sys) begin
        if (clear_all) begin
          sensor_channel_config[g] <= RSC_CFG_RESET; // RQ4 RQ8
        end else if (wr_cfg[g]) begin
          sensor_channel_config[g] <= reg_wdata & RSC_CFG_MASK; // RQ4 RQ11
        end
      end
      rsc_chan u_chan (
        .cfg(sensor_channel_config[g]),
        .track_slow(tracking_rate_halve[g]),
        .use_start_period(start_period_decode_use[g]),
        .blank_long(limit_blanking_long[g]),
        .frame_format(fmt)
      );
      assign sensor_frame_format[g*4 +: 4] = fmt;
    end
  endgenerate

  assign channel_output_on = {sensor_channel_control[RSC_CH1_ON_BIT],
                              sensor_channel_control[RSC_CH0_ON_BIT]}; // RQ9
  assign channel_on_status = on_status;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire logic hit_cfg1 = (reg_addr == RSC_ADDR_CFG1);
  wire logic hit_cfg2 = (reg_addr == RSC_ADDR_CFG2);
  wire logic hit_ctrl = (reg_addr == RSC_ADDR_CTRL);
  logic [15:0] next_rdata;
  always_comb begin
    if (hit_cfg1) begin
      next_rdata = sensor_channel_config[0];
    end else if (hit_cfg2) begin
      next_rdata = sensor_channel_config[1];
    end else if (hit_ctrl) begin
      next_rdata = sensor_channel_control; // RQ9
    end else begin
      next_rdata = 16'h0000; // RQ11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: verif/rsc_props.sv */
// Purpose: port checks for rsc_top
// Assumes: rst sync active high
// Notes: bound from testbench
`default_nettype none
module rsc_props #(parameter int CHANNELS = 2) (
  input wire logic clk_sys, rst, state_machine_reinit, reg_write,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  input wire logic [CHANNELS-1:0] tracking_rate_halve, start_period_decode_use, limit_blanking_long,
  input wire logic [CHANNELS-1:0] channel_output_on, channel_on_status,
  input wire logic [CHANNELS*4-1:0] sensor_frame_format
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire wok = reg_write && !state_machine_reinit;
  wire wa = wok && reg_addr == 7'h4a;
  wire wc = wok && reg_addr == 7'h4e;
  track_sel_a: assert property (wa |=> tracking_rate_halve[0] == $past(reg_wdata[14])) else $error("track");
  start_use_a: assert property (wa |=> start_period_decode_use[0] != $past(reg_wdata[13])) else $error("start");
  blank_sel_a: assert property (wok && reg_addr == 7'h4b |=> limit_blanking_long[1] == $past(reg_wdata[10]))
    else $error("blank");
  hold_idle_a: assert property (!reg_write && !state_machine_reinit |=> $stable(sensor_frame_format)
    && $stable(channel_output_on)) else $error("hold");
  fmt_map_a: assert property (wa |=> sensor_frame_format[3:0] == ($past(reg_wdata[3:0]) > 3 ? 4'h8
    : 4'h1 << $past(reg_wdata[1:0]))) else $error("format");
  reinit_clr_a: assert property (state_machine_reinit |=> sensor_frame_format[3:0] == 4'h1
    && channel_on_status == 0) else $error("reinit");
  ctrl_bits_a: assert property (wc |=> channel_output_on == {$past(reg_wdata[3]), $past(reg_wdata[1])})
    else $error("ctrl");
  status_on_a: assert property (wc |=> channel_on_status == channel_output_on) else $error("status");
  rsvd_zero_a: assert property (reg_addr == 7'h4e |=> (reg_rdata & 16'hfff5) == 16'h0) else $error("rsvd");
endmodule
`default_nettype wire

/* File: verif/rsc_sat_model.sv */
// Purpose: satellite sensors, powered while their line is on
// Assumes: one satellite per channel
// Notes: supply modelled as a level
`default_nettype none
module rsc_sat_model (
  input wire logic clk_sys,
  input wire logic [1:0] line_on,
  output logic [1:0] sat_powered
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_sys) sat_powered <= line_on;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: self-checking bench for rsc_top
// Assumes: inputs driven at falling edge
// Notes: ends through end_sim
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst = 1'b1, state_machine_reinit = 1'b0, reg_write = 1'b0;
  logic [6:0] reg_addr = 7'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  logic [1:0] tracking_rate_halve, start_period_decode_use, limit_blanking_long;
  logic [1:0] channel_output_on, channel_on_status, sat_powered;
  logic [7:0] sensor_frame_format;
  int fails = 0, checks = 0, cyc = 0;
  rsc_top #(.CHANNELS(2)) i_dut (.clk_sys, .rst, .state_machine_reinit, .reg_addr, .reg_write, .reg_wdata,
    .reg_rdata, .tracking_rate_halve, .start_period_decode_use, .limit_blanking_long, .sensor_frame_format,
    .channel_output_on, .channel_on_status);
  rsc_sat_model i_sat (.clk_sys, .line_on(channel_output_on), .sat_powered);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk_sys);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask
  task automatic t_cfg();
    rd(7'h4b, 16'h0);
    wr(7'h4a, 16'hffff);
    chk({10'h0, tracking_rate_halve, start_period_decode_use, limit_blanking_long}, 16'h0019);
    rd(7'h4a, 16'h640f);
    for (int c = 0; c < 16; c++) begin
      wr(7'h4b, 16'(c));
      chk({12'h0, sensor_frame_format[7:4]}, c > 3 ? 16'h8 : 16'h1 << c);
    end
    $display("cfg test done");
  endtask
  task automatic t_ctrl();
    wr(7'h4e, 16'hffff);
    rd(7'h4e, 16'h000a);
    wr(7'h4e, 16'h0008);
    wr(7'h4c, 16'hffff);
    rd(7'h4c, 16'h0);
    chk({10'h0, channel_output_on, channel_on_status, sat_powered}, 16'h002a);
    $display("ctrl test done");
  endtask
  task automatic t_reinit();
    @(negedge clk_sys);
    state_machine_reinit = 1'b1;
    reg_addr = 7'h4e;
    reg_wdata = 16'hffff;
    reg_write = 1'b1;
    @(negedge clk_sys);
    state_machine_reinit = 1'b0;
    reg_write = 1'b0;
    chk({channel_output_on, channel_on_status, sensor_frame_format, limit_blanking_long, tracking_rate_halve},
      16'h0110);
    $display("reinit test done");
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    t_cfg();
    t_ctrl();
    t_reinit();
    end_sim();
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_sim();
    end
  end
endmodule
bind rsc_top rsc_props #(.CHANNELS(CHANNELS)) i_props (.clk_sys, .rst, .state_machine_reinit, .reg_write,
  .reg_addr, .reg_wdata, .reg_rdata, .tracking_rate_halve, .start_period_decode_use, .limit_blanking_long,
  .channel_output_on, .channel_on_status, .sensor_frame_format);
`default_nettype wire
